// >>> verilog/sci_consts.svh
// register offsets, field positions, reset values for the serial control block
`ifndef SCI_CONSTS_SVH
`define SCI_CONSTS_SVH

`define SCI_OFF_CTRL0      8'h00
`define SCI_OFF_STATUS     8'h01
`define SCI_OFF_INT_STATUS 8'h02
`define SCI_OFF_INT_CLEAR  8'h03
`define SCI_OFF_INT_ENABLE 8'h04

`define SCI_CTRL_RX_CLR_BIT 3
`define SCI_CTRL_TX_CLR_BIT 2
`define SCI_CTRL_RX_EN_BIT  1
`define SCI_CTRL_TX_EN_BIT  0

`define SCI_ST_ERR_SUM_BIT  6
`define SCI_ST_FRAME_BIT    5
`define SCI_ST_PARITY_BIT   4
`define SCI_ST_OVERRUN_BIT  3
`define SCI_ST_RX_DONE_BIT  2
`define SCI_ST_TX_DONE_BIT  1
`define SCI_ST_TX_EMPTY_BIT 0
`define SCI_ST_RX_MASK      8'h7c
`define SCI_ST_TX_MASK      8'h03

`define SCI_INT_W           6
`define SCI_INT_RX_DONE     0
`define SCI_INT_RX_ERR      1
`define SCI_INT_TX_DONE     2
`define SCI_INT_TX_EMPTY    3
`define SCI_INT_RX_HALT     4
`define SCI_INT_TX_HALT     5

`define SCI_CTRL0_RST       8'h00
`define SCI_STATUS_RST      8'h00
`define SCI_INT_RST         6'h00

`endif

// >>> verilog/sci_pkg.sv
// types of the serial control block
package sci_pkg;

  typedef enum logic [2:0]
  {
    SCI_EN_OFF   = 3'b001,
    SCI_EN_ON    = 3'b010,
    SCI_EN_DRAIN = 3'b100
  } sci_en_state_t;

  typedef struct packed
  {
    sci_en_state_t rx_st;
    sci_en_state_t tx_st;
    logic          rx_bit;
    logic          tx_bit;
    logic          rx_clr;
    logic          tx_clr;
    logic          rx_halt;
    logic          tx_halt;
    logic [5:0]    int_status;
    logic [5:0]    int_enable;
    logic [7:0]    rdata;
  } sci_ctrl_state_t;

  typedef struct packed
  {
    logic [7:0] flags;
  } sci_stat_state_t;

endpackage

// >>> verilog/sci_stat_if.sv
// carrier between the control logic and the serial status flags
`timescale 1ns/1ps
interface sci_stat_if;
  logic       rx_clr;
  logic       tx_clr;
  logic       frame_err;
  logic       parity_err;
  logic       overrun_err;
  logic       rx_done;
  logic       tx_done;
  logic       tx_empty;
  logic [7:0] flags;

  modport ctrl
  (
    output rx_clr,
    output tx_clr,
    output frame_err,
    output parity_err,
    output overrun_err,
    output rx_done,
    output tx_done,
    output tx_empty,
    input  flags
  );

  modport stat
  (
    input  rx_clr,
    input  tx_clr,
    input  frame_err,
    input  parity_err,
    input  overrun_err,
    input  rx_done,
    input  tx_done,
    input  tx_empty,
    output flags
  );
endinterface

// >>> verilog/sci_status.sv
// serial status flags with receiver and transmitter initialise strobes
`timescale 1ns/1ps
`include "sci_consts.svh"
module sci_status
(
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic ce_in,
  sci_stat_if.stat  st
);

  sci_pkg::sci_stat_state_t r;
  sci_pkg::sci_stat_state_t n;
  logic [7:0]               set_vec;
  logic [7:0]               clr_vec;

  always_comb
  begin
    set_vec = 8'h00;
    set_vec[`SCI_ST_ERR_SUM_BIT]  = st.frame_err | st.parity_err | st.overrun_err;
    set_vec[`SCI_ST_FRAME_BIT]    = st.frame_err;
    set_vec[`SCI_ST_PARITY_BIT]   = st.parity_err;
    set_vec[`SCI_ST_OVERRUN_BIT]  = st.overrun_err;
    set_vec[`SCI_ST_RX_DONE_BIT]  = st.rx_done;
    set_vec[`SCI_ST_TX_DONE_BIT]  = st.tx_done;
    set_vec[`SCI_ST_TX_EMPTY_BIT] = st.tx_empty;
    clr_vec = (st.rx_clr ? `SCI_ST_RX_MASK : 8'h00)
            | (st.tx_clr ? `SCI_ST_TX_MASK : 8'h00);
    // an event landing on the clear cycle survives the clear
    n.flags = (r.flags & ~clr_vec) | set_vec;
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      r.flags <= `SCI_STATUS_RST;
    end
    else if (ce_in)
    begin
      r <= n;
    end
  end

  assign st.flags = r.flags;

endmodule // sci_status

// >>> verilog/sci_ctrl.sv
// serial channel control register: flag initialise strobes and frame-safe enables
`timescale 1ns/1ps
`include "sci_consts.svh"
module sci_ctrl
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              REF_CLK_IN,
  input  wire logic              NRST_IN,
  input  wire logic              CE_IN,
  input  wire logic [ADDR_W-1:0] ADDR_IN,
  input  wire logic [7:0]        WDATA_IN,
  input  wire logic              WR_IN,
  input  wire logic              RD_IN,
  output logic      [7:0]        RDATA_OUT,
  input  wire logic              RX_FRAME_ACTIVE_IN,
  input  wire logic              TX_FRAME_ACTIVE_IN,
  input  wire logic              RX_FRAME_ERR_IN,
  input  wire logic              RX_PARITY_ERR_IN,
  input  wire logic              RX_OVERRUN_ERR_IN,
  input  wire logic              RX_DONE_IN,
  input  wire logic              TX_DONE_IN,
  input  wire logic              TX_EMPTY_IN,
  output logic                   RX_ENABLE_OUT,
  output logic                   TX_ENABLE_OUT,
  output logic                   RX_FLAG_CLR_OUT,
  output logic                   TX_FLAG_CLR_OUT,
  output logic      [7:0]        STATUS_OUT,
  output logic                   IRQ_OUT
);

  generate
    if (ADDR_W < 3 || ADDR_W > 8)
    begin : g_bad_addr_w
      $error("sci_ctrl: ADDR_W must lie between 3 and 8");
    end
  endgenerate

  // the interrupt field of the state struct is six bits wide
  generate
    if (`SCI_INT_W != 6)
    begin : g_bad_int_w
      $error("sci_ctrl: the interrupt field must be 6 bits wide");
    end
  endgenerate

  // the two flag clear masks split the seven status flags with no overlap
  generate
    if (((`SCI_ST_RX_MASK & `SCI_ST_TX_MASK) != 8'h00) ||
        ((`SCI_ST_RX_MASK | `SCI_ST_TX_MASK) != 8'h7f))
    begin : g_bad_masks
      $error("sci_ctrl: status clear masks overlap or miss a flag");
    end
  endgenerate

  // the four control bits must sit in the low nibble, each in its own place
  generate
    if (`SCI_CTRL_RX_CLR_BIT > 3 || `SCI_CTRL_TX_CLR_BIT > 3 ||
        `SCI_CTRL_RX_EN_BIT > 3 || `SCI_CTRL_TX_EN_BIT > 3 ||
        ((4'h1 << `SCI_CTRL_RX_CLR_BIT) | (4'h1 << `SCI_CTRL_TX_CLR_BIT) |
         (4'h1 << `SCI_CTRL_RX_EN_BIT) | (4'h1 << `SCI_CTRL_TX_EN_BIT)) != 4'hf)
    begin : g_bad_ctrl_pos
      $error("sci_ctrl: control bit positions collide or leave the low nibble");
    end
  endgenerate

  // each interrupt source needs its own bit inside the interrupt field
  generate
    if (`SCI_INT_RX_DONE >= `SCI_INT_W || `SCI_INT_RX_ERR >= `SCI_INT_W ||
        `SCI_INT_TX_DONE >= `SCI_INT_W || `SCI_INT_TX_EMPTY >= `SCI_INT_W ||
        `SCI_INT_RX_HALT >= `SCI_INT_W || `SCI_INT_TX_HALT >= `SCI_INT_W)
    begin : g_bad_int_pos
      $error("sci_ctrl: an interrupt bit lies outside the interrupt field");
    end
  endgenerate

  // status bit 7 has no flag, so every flag position must lie below it
  generate
    if (`SCI_ST_ERR_SUM_BIT > 6 || `SCI_ST_FRAME_BIT > 6 || `SCI_ST_PARITY_BIT > 6 ||
        `SCI_ST_OVERRUN_BIT > 6 || `SCI_ST_RX_DONE_BIT > 6 || `SCI_ST_TX_DONE_BIT > 6 ||
        `SCI_ST_TX_EMPTY_BIT > 6)
    begin : g_bad_st_pos
      $error("sci_ctrl: a status flag position lies outside bits 6 to 0");
    end
  endgenerate

  sci_pkg::sci_ctrl_state_t r;
  sci_pkg::sci_ctrl_state_t n;
  sci_stat_if               stat_bus ();

  logic [`SCI_INT_W-1:0] int_set;
  logic [`SCI_INT_W-1:0] int_clr;
  logic [`SCI_INT_W-1:0] int_next;
  logic [7:0]            addr_ext;
  logic                  wr_ctrl;
  logic                  wr_int_clr;
  logic                  wr_int_en;
  logic [7:0]            rd_word;
  logic                   ch_bit       [2];
  logic                   ch_active    [2];
  logic                   ch_halt_next [2];
  sci_pkg::sci_en_state_t ch_st        [2];
  sci_pkg::sci_en_state_t ch_next      [2];

  // one step of the frame-safe enable: a drop of the enable bit while a
  // character is on the wire parks in drain until the frame ends
  function automatic sci_pkg::sci_en_state_t sci_en_step
  (
    input sci_pkg::sci_en_state_t st,
    input logic                   en_bit,
    input logic                   frame_active
  );
    sci_pkg::sci_en_state_t nx;
    nx = st;
    case (st)
      sci_pkg::SCI_EN_OFF:
      begin
        if (en_bit)
        begin
          nx = sci_pkg::SCI_EN_ON;
        end
      end
      sci_pkg::SCI_EN_ON:
      begin
        if (!en_bit)
        begin
          nx = frame_active ? sci_pkg::SCI_EN_DRAIN : sci_pkg::SCI_EN_OFF;
        end
      end
      sci_pkg::SCI_EN_DRAIN:
      begin
        if (en_bit)
        begin
          nx = sci_pkg::SCI_EN_ON;
        end
        else if (!frame_active)
        begin
          nx = sci_pkg::SCI_EN_OFF;
        end
      end
      default:
      begin
        nx = sci_pkg::SCI_EN_OFF;
      end
    endcase
    return nx;
  endfunction

  // the offsets are at most eight bits wide, so widen the address to match
  assign addr_ext = 8'(ADDR_IN);

  always_comb
  begin
    wr_ctrl    = 1'b0;
    wr_int_clr = 1'b0;
    wr_int_en  = 1'b0;
    if (WR_IN)
    begin
      if (addr_ext == `SCI_OFF_CTRL0)
      begin
        wr_ctrl = 1'b1;
      end
      else if (addr_ext == `SCI_OFF_INT_CLEAR)
      begin
        wr_int_clr = 1'b1;
      end
      else if (addr_ext == `SCI_OFF_INT_ENABLE)
      begin
        wr_int_en = 1'b1;
      end
    end
  end

  // per-bit sticky interrupt status; a new event beats a same-cycle clear
  assign int_clr = wr_int_clr ? WDATA_IN[`SCI_INT_W-1:0] : `SCI_INT_RST;

  always_comb
  begin
    int_set = `SCI_INT_RST;
    int_set[`SCI_INT_RX_DONE]  = RX_DONE_IN;
    int_set[`SCI_INT_RX_ERR]   = RX_FRAME_ERR_IN | RX_PARITY_ERR_IN | RX_OVERRUN_ERR_IN;
    int_set[`SCI_INT_TX_DONE]  = TX_DONE_IN;
    int_set[`SCI_INT_TX_EMPTY] = TX_EMPTY_IN;
    int_set[`SCI_INT_RX_HALT]  = r.rx_halt;
    int_set[`SCI_INT_TX_HALT]  = r.tx_halt;
  end

  genvar gi;
  generate
    for (gi = 0; gi < `SCI_INT_W; gi = gi + 1)
    begin : g_int_bit
      assign int_next[gi] = int_set[gi] | (r.int_status[gi] & ~int_clr[gi]);
    end
  endgenerate

  // channel 0 is the receiver, channel 1 the transmitter; the enable state
  // follows the freshly written bit in the same edge
  always_comb
  begin
    ch_st[0]     = r.rx_st;
    ch_st[1]     = r.tx_st;
    ch_active[0] = RX_FRAME_ACTIVE_IN;
    ch_active[1] = TX_FRAME_ACTIVE_IN;
    ch_bit[0]    = r.rx_bit;
    ch_bit[1]    = r.tx_bit;
    if (wr_ctrl)
    begin
      ch_bit[0] = WDATA_IN[`SCI_CTRL_RX_EN_BIT];
      ch_bit[1] = WDATA_IN[`SCI_CTRL_TX_EN_BIT];
    end
  end

  genvar gc;
  generate
    for (gc = 0; gc < 2; gc = gc + 1)
    begin : g_chan
      assign ch_next[gc] = sci_en_step(ch_st[gc], ch_bit[gc], ch_active[gc]);
      // halt is flagged only when a drain ends, not on an idle disable
      assign ch_halt_next[gc] = (ch_st[gc] == sci_pkg::SCI_EN_DRAIN) &&
                                (ch_next[gc] == sci_pkg::SCI_EN_OFF);
    end
  endgenerate

  // read decode; the write-only clear register and unmapped offsets read zero
  always_comb
  begin
    rd_word = 8'h00;
    if (addr_ext == `SCI_OFF_CTRL0)
    begin
      // clear bits read back their strobe, which is zero once it has fired
      rd_word[`SCI_CTRL_RX_CLR_BIT] = r.rx_clr;
      rd_word[`SCI_CTRL_TX_CLR_BIT] = r.tx_clr;
      rd_word[`SCI_CTRL_RX_EN_BIT]  = r.rx_bit;
      rd_word[`SCI_CTRL_TX_EN_BIT]  = r.tx_bit;
    end
    else if (addr_ext == `SCI_OFF_STATUS)
    begin
      rd_word = stat_bus.flags;
    end
    else if (addr_ext == `SCI_OFF_INT_STATUS)
    begin
      rd_word = {2'b00, r.int_status};
    end
    else if (addr_ext == `SCI_OFF_INT_ENABLE)
    begin
      rd_word = {2'b00, r.int_enable};
    end
    else
    begin
      rd_word = 8'h00;
    end
  end

  always_comb
  begin
    n = r;
    // the clear strobes live for one clock-enabled cycle; they hold while CE_IN is low
    n.rx_clr = 1'b0;
    n.tx_clr = 1'b0;
    n.rdata  = 8'h00;

    if (wr_ctrl)
    begin
      // a zero in a clear bit leaves the strobe low and the flags alone
      n.rx_clr = WDATA_IN[`SCI_CTRL_RX_CLR_BIT];
      n.tx_clr = WDATA_IN[`SCI_CTRL_TX_CLR_BIT];
      n.rx_bit = WDATA_IN[`SCI_CTRL_RX_EN_BIT];
      n.tx_bit = WDATA_IN[`SCI_CTRL_TX_EN_BIT];
    end
    if (wr_int_en)
    begin
      n.int_enable = WDATA_IN[`SCI_INT_W-1:0];
    end
    n.int_status = int_next;

    n.rx_st   = ch_next[0];
    n.tx_st   = ch_next[1];
    n.rx_halt = ch_halt_next[0];
    n.tx_halt = ch_halt_next[1];

    if (RD_IN)
    begin
      n.rdata = rd_word;
    end
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (!NRST_IN)
    begin
      r.rx_st      <= sci_pkg::SCI_EN_OFF;
      r.tx_st      <= sci_pkg::SCI_EN_OFF;
      r.rx_bit     <= 1'(`SCI_CTRL0_RST >> `SCI_CTRL_RX_EN_BIT);
      r.tx_bit     <= 1'(`SCI_CTRL0_RST >> `SCI_CTRL_TX_EN_BIT);
      r.rx_clr     <= 1'b0;
      r.tx_clr     <= 1'b0;
      r.rx_halt    <= 1'b0;
      r.tx_halt    <= 1'b0;
      r.int_status <= `SCI_INT_RST;
      r.int_enable <= `SCI_INT_RST;
      r.rdata      <= 8'h00;
    end
    else if (CE_IN)
    begin
      r <= n;
    end
  end

  // status flags sit in their own module; they are cleared one edge after
  // the strobe rises, so the clear is seen on the strobe's only cycle
  assign stat_bus.rx_clr      = r.rx_clr;
  assign stat_bus.tx_clr      = r.tx_clr;
  assign stat_bus.frame_err   = RX_FRAME_ERR_IN;
  assign stat_bus.parity_err  = RX_PARITY_ERR_IN;
  assign stat_bus.overrun_err = RX_OVERRUN_ERR_IN;
  assign stat_bus.rx_done     = RX_DONE_IN;
  assign stat_bus.tx_done     = TX_DONE_IN;
  assign stat_bus.tx_empty    = TX_EMPTY_IN;

  sci_status u_status
  (
    .clk_in  (REF_CLK_IN),
    .nrst_in (NRST_IN),
    .ce_in   (CE_IN),
    .st      (stat_bus)
  );

  // a character already on the wire is not cut short: drain keeps it going
  assign RX_ENABLE_OUT   = r.rx_st != sci_pkg::SCI_EN_OFF;
  assign TX_ENABLE_OUT   = r.tx_st != sci_pkg::SCI_EN_OFF;
  assign RX_FLAG_CLR_OUT = r.rx_clr;
  assign TX_FLAG_CLR_OUT = r.tx_clr;
  assign RDATA_OUT       = r.rdata;
  assign STATUS_OUT      = stat_bus.flags;
  assign IRQ_OUT         = |(r.int_status & r.int_enable);

endmodule // sci_ctrl

// >>> tb/sci_ctrl_monitor.sv
// port checker for the serial control block
`timescale 1ns/1ps
module sci_ctrl_monitor
#(
  parameter int ADDR_W = 8
)
(
  input wire logic              REF_CLK_IN,
  input wire logic              NRST_IN,
  input wire logic              CE_IN,
  input wire logic [ADDR_W-1:0] ADDR_IN,
  input wire logic [7:0]        WDATA_IN,
  input wire logic              WR_IN,
  input wire logic              RX_FRAME_ACTIVE_IN,
  input wire logic              TX_FRAME_ACTIVE_IN,
  input wire logic              RX_FRAME_ERR_IN,
  input wire logic              RX_PARITY_ERR_IN,
  input wire logic              RX_OVERRUN_ERR_IN,
  input wire logic              RX_DONE_IN,
  input wire logic              TX_DONE_IN,
  input wire logic              TX_EMPTY_IN,
  input wire logic              RX_ENABLE_OUT,
  input wire logic              TX_ENABLE_OUT,
  input wire logic              RX_FLAG_CLR_OUT,
  input wire logic              TX_FLAG_CLR_OUT,
  input wire logic [7:0]        STATUS_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!NRST_IN);
  logic wr0;
  logic ev;
  assign wr0 = WR_IN && CE_IN && ADDR_IN == '0;
  // set wins over clear, so any event makes the clear checks vacuous
  assign ev = RX_FRAME_ERR_IN || RX_PARITY_ERR_IN || RX_OVERRUN_ERR_IN || RX_DONE_IN ||
              TX_DONE_IN || TX_EMPTY_IN;

  rx_strobe_a: assert property ($past(CE_IN) |->
    RX_FLAG_CLR_OUT == $past(wr0 && WDATA_IN[3] && NRST_IN)) else $error("rx clear strobe");
  tx_strobe_a: assert property ($past(CE_IN) |->
    TX_FLAG_CLR_OUT == $past(wr0 && WDATA_IN[2] && NRST_IN)) else $error("tx clear strobe");
  rx_init_a: assert property (CE_IN && RX_FLAG_CLR_OUT && !TX_FLAG_CLR_OUT && !ev |=>
    STATUS_OUT == ($past(STATUS_OUT) & 8'h03)) else $error("rx flag init");
  tx_init_a: assert property (CE_IN && TX_FLAG_CLR_OUT && !RX_FLAG_CLR_OUT && !ev |=>
    STATUS_OUT == ($past(STATUS_OUT) & 8'h7c)) else $error("tx flag init");
  rx_drain_a: assert property (RX_ENABLE_OUT && RX_FRAME_ACTIVE_IN |=> RX_ENABLE_OUT)
    else $error("rx stopped mid frame");
  tx_drain_a: assert property (TX_ENABLE_OUT && TX_FRAME_ACTIVE_IN |=> TX_ENABLE_OUT)
    else $error("tx stopped mid frame");
  rx_on_a: assert property (wr0 && WDATA_IN[1] |=> RX_ENABLE_OUT)
    else $error("rx not enabled");
  rx_off_a: assert property (wr0 && !WDATA_IN[1] && !RX_FRAME_ACTIVE_IN |=> !RX_ENABLE_OUT)
    else $error("rx not blocked");
  tx_on_a: assert property (wr0 && WDATA_IN[0] |=> TX_ENABLE_OUT)
    else $error("tx not enabled");
  tx_off_a: assert property (wr0 && !WDATA_IN[0] && !TX_FRAME_ACTIVE_IN |=> !TX_ENABLE_OUT)
    else $error("tx not blocked");

  cover property (RX_ENABLE_OUT && RX_FRAME_ACTIVE_IN ##1 !RX_FRAME_ACTIVE_IN ##1 !RX_ENABLE_OUT);
  cover property (RX_FLAG_CLR_OUT);
  cover property (TX_FLAG_CLR_OUT);
  cover property (TX_ENABLE_OUT && TX_FRAME_ACTIVE_IN ##1 !TX_FRAME_ACTIVE_IN ##1 !TX_ENABLE_OUT);
endmodule // sci_ctrl_monitor

bind sci_ctrl sci_ctrl_monitor #(.ADDR_W(ADDR_W)) sci_ctrl_monitor_i (.*);

// >>> tb/sci_peer.sv
// serial peer model: frame activity and end-of-frame event pulses
`timescale 1ns/1ps
module sci_peer
(
  input  wire logic       clk_in,
  input  wire logic       go_in,
  input  wire logic [2:0] err_in,
  output logic            act_out,
  output logic            done_out,
  output logic [2:0]      err_out
);
  int cnt = 0;
  initial
  begin
    done_out = 1'b0;
    err_out = 3'h0;
  end
  // a character lasts five cycles; events only at its end
  always @(posedge clk_in)
  begin
    done_out <= cnt == 1;
    err_out <= cnt == 1 ? err_in : 3'h0;
    if (go_in && cnt == 0)
      cnt <= 5;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
  assign act_out = cnt != 0;
endmodule // sci_peer

// >>> tb/sci_ctrl_bench.sv
// self-checking bench for the serial control block
`timescale 1ns/1ps
module sci_ctrl_bench;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       ce = 1'b0, wr = 1'b0, rd = 1'b0, rgo = 1'b0, tgo = 1'b0, temp = 1'b0, q;
  logic [7:0] adr = 8'h00, wd = 8'h00, d, rdata, stat, ms, mie, mrd;
  logic [2:0] rerr_i = 3'h0, rerr;
  logic [5:0] mi;
  logic       ract, tact, rdone, tdone, ren, ten, rclr, tclr, irq;
  logic       mrc, mtc, mrq, mtq, mre, mte, mrh, mth, rdr, tdr;
  int         error_cnt = 0, samples_checked = 0, r, a;
  always #4 clk = ~clk;

  sci_ctrl sci_ctrl_i (.REF_CLK_IN(clk), .NRST_IN(rst_n), .CE_IN(ce), .ADDR_IN(adr),
    .WDATA_IN(wd), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .RX_FRAME_ACTIVE_IN(ract),
    .TX_FRAME_ACTIVE_IN(tact), .RX_FRAME_ERR_IN(rerr[2]), .RX_PARITY_ERR_IN(rerr[1]),
    .RX_OVERRUN_ERR_IN(rerr[0]), .RX_DONE_IN(rdone), .TX_DONE_IN(tdone), .TX_EMPTY_IN(temp),
    .RX_ENABLE_OUT(ren), .TX_ENABLE_OUT(ten), .RX_FLAG_CLR_OUT(rclr), .TX_FLAG_CLR_OUT(tclr),
    .STATUS_OUT(stat), .IRQ_OUT(irq));
  sci_peer sci_peer_i (.clk_in(clk), .go_in(rgo), .err_in(rerr_i), .act_out(ract),
    .done_out(rdone), .err_out(rerr));
  sci_peer sci_peer_tx_i (.clk_in(clk), .go_in(tgo), .err_in(3'h0), .act_out(tact),
    .done_out(tdone), .err_out());

  // reference model; a halt bit marks a drain that has run to its end
  always @(posedge clk)
  begin
    if (!rst_n)
      {ms, mi, mie, mrd, mrc, mtc, mrq, mtq, mre, mte, mrh, mth} = '0;
    else if (ce)
    begin
      mrd = 8'h00;
      if (rd && adr == 8'h00)
        mrd = {4'h0, mrc, mtc, mrq, mtq};
      if (rd && adr == 8'h01)
        mrd = ms;
      if (rd && adr == 8'h02)
        mrd = {2'h0, mi};
      if (rd && adr == 8'h04)
        mrd = mie;
      ms = (ms & ~((mrc ? 8'h7c : 8'h00) | (mtc ? 8'h03 : 8'h00))) |
           {1'b0, |rerr, rerr, rdone, tdone, temp};
      mi = (mi & ~(wr && adr == 8'h03 ? wd[5:0] : 6'h00)) |
           {mth, mrh, temp, tdone, |rerr, rdone};
      if (wr && adr == 8'h04)
        mie = wd;
      rdr = mre && !mrq;
      tdr = mte && !mtq;
      mrc = wr && adr == 8'h00 && wd[3];
      mtc = wr && adr == 8'h00 && wd[2];
      if (wr && adr == 8'h00)
        {mrq, mtq} = wd[1:0];
      mre = mrq || (mre && ract);
      mte = mtq || (mte && tact);
      mrh = rdr && !mre;
      mth = tdr && !mte;
    end
  end

  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    stop_test();
  end

  initial
  begin
    void'($urandom(85866));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 3000; i++)
    begin
      @(posedge clk);
      r = $urandom % 16;
      a = $urandom % 8;
      d = $urandom;
      if (ract)
        d[3] = 1'b0;
      if (tact)
        d[2] = 1'b0;
      q = i inside {[1500:1503]};
      rst_n <= !(i inside {[1500:1502]});
      ce <= r != 0;
      wr <= !q && r inside {[1:7]};
      rd <= !q && r inside {[8:10]};
      adr <= r < 5 ? 8'h00 : r == 5 ? 8'h03 : r == 6 ? 8'h04 : 8'(a);
      wd <= (r == 6 || a == 4) ? d & 8'h3f : d;
      rgo <= ren && $urandom % 4 == 0;
      tgo <= ten && $urandom % 4 == 0;
      rerr_i <= $urandom % 4 == 0 ? 3'($urandom) : 3'h0;
      temp <= $urandom % 8 == 0;
      @(negedge clk);
      chk({rdata, stat, ren, ten, rclr, tclr, irq},
          {mrd, ms, mre, mte, mrc, mtc, |(mi & mie[5:0])});
    end
    stop_test();
  end
endmodule // sci_ctrl_bench
